// File: hdl/ebir_top.sv
// External bus idle-cycle insertion and bus release controller
// Operation
// R01 - Release requests are accepted only in extended mode with release and buffer enables set.
// R02 - The external master holds its active-low request low as long as it wants the bus.
// R03 - A sampled request drives acknowledge low and floats address, data and control pins.
// R04 - Internal-space accesses continue while the bus is released.
// R05 - External accesses wait before their cycle starts until the request is withdrawn.
// R06 - A clock-frequency write made during release takes effect after the request ends.
// R07 - With cancel enable set and bus released, external access, standby sleep or clock write pulls cancel low.
// R08 - A release request wins over a simultaneous external access.
// R09 - In release, address, data, chip selects and all strobes float.
// R10 - Idle cycles drive the next address, float data, hold strobes high and address hold low.
// R11 - Read-read idle in a new area inserts count A or B by the previous area's select bit.
// R12 - Write after read inserts count A or B by the previous area's select bit.
// R13 - Read after write inserts count A only.
// R14 - Count A codes give 1 to 4 cycles, count B codes 0,2,3,4; reset gives four everywhere.
// R15 - On request withdrawal acknowledge rises and the bus is driven before deferred cycles.
// R16 - Non-external cycles since the last access count toward the idle requirement.
`timescale 1ns/10ps
module ebir_top
	import ebir_pkg::*;
(
	input  wire logic              CLK_SYS,
	input  wire logic              RST,
	input  wire logic              EXT_EXTENDED_MODE,
	input  wire logic              RELEASE_ENABLE,
	input  wire logic              INPUT_BUFFER_CTRL,
	input  wire logic              CANCEL_REQUEST_OUT_ENABLE,
	input  wire logic              IDLE_ENABLE_READ_AFTER_WRITE,
	input  wire logic              IDLE_ENABLE_READ_READ,
	input  wire logic              IDLE_ENABLE_WRITE_AFTER_READ,
	input  wire logic [AREA_N-1:0] IDLE_SETTING_SELECT,
	input  wire logic [1:0]        IDLE_COUNT_A,
	input  wire logic [1:0]        IDLE_COUNT_B,
	input  wire logic              EXT_BUS_REQUEST_N,
	input  wire logic              ACC_REQ,
	input  wire logic              ACC_WRITE,
	input  wire logic [AREA_W-1:0] ACC_AREA,
	input  wire logic [ADDR_W-1:0] ACC_ADDR,
	input  wire logic [DATA_W-1:0] ACC_WDATA,
	input  wire logic              SLEEP_STANDBY_REQ,
	input  wire logic              CLK_SET_WR,
	input  wire logic [CLK_W-1:0]  CLK_SET_DATA,
	output logic                   ACC_DONE,
	output logic                   ACC_STALL,
	output logic [CLK_W-1:0]       CLK_SETTING,
	output logic                   BUS_ACK_N,
	output logic                   RELEASE_CANCEL_REQUEST_N,
	output logic [ADDR_W-1:0]      ADDR_O,
	output logic                   ADDR_OE_N,
	output logic [DATA_W-1:0]      DATA_O,
	output logic                   DATA_OE_N,
	output logic [AREA_N-1:0]      CHIP_SELECT_N,
	output logic                   ADDR_STROBE_N,
	output logic                   READ_N,
	output logic                   BUS_START_N,
	output logic                   READ_WRITE_N,
	output logic                   ADDR_HOLD_N,
	output logic                   UPPER_WRITE_STROBE_N,
	output logic                   LOWER_WRITE_STROBE_N,
	output logic                   UPPER_BYTE_SELECT_N,
	output logic                   LOWER_BYTE_SELECT_N,
	output logic                   CTRL_OE_N
);
	ebir_state_t      st_q, st_d;
	ebir_last_t       last_q, last_d;
	logic [AREA_W-1:0] area_q, area_d;
	logic [CNT_W-1:0] gap_q, gap_d, need_q, need_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [DATA_W-1:0] data_q, data_d;
	logic [AREA_N-1:0] cs_q, cs_d;
	logic             wr_q, wr_d, ack_q, ack_d, cancel_q, cancel_d;
	logic             float_q, float_d, wrs_n_q, wrs_n_d, rd_n_q, rd_n_d;
	logic             done_q, done_d, stall_q, stall_d, hz_q, hz_d, strb_n_q, strb_n_d;
	logic             rel_ok;
	logic             clk_pending;
	logic [CLK_W-1:0] clk_setting;

	// Idle cycles implied by a 2-bit code, B code 00 meaning none
	function automatic logic [CNT_W-1:0] idle_cycles(input logic [1:0] code, input logic is_b);
		if (is_b && code == 2'h0)
			idle_cycles = CNT_ZERO;
		else
			idle_cycles = {1'b0, code} + CNT_ONE; // R14
	endfunction

	// Required idle count for the next access given the previous one
	function automatic logic [CNT_W-1:0] idle_need(input ebir_last_t last,
		input logic prev_sel, input logic nwr, input logic same_area);
		logic [CNT_W-1:0] ab;
		ab = prev_sel ? idle_cycles(IDLE_COUNT_B, 1'b1) : idle_cycles(IDLE_COUNT_A, 1'b0);
		idle_need = CNT_ZERO;
		if (last == EBIR_LAST_READ && !nwr && !same_area && IDLE_ENABLE_READ_READ)
			idle_need = ab; // R11
		else if (last == EBIR_LAST_READ && nwr && IDLE_ENABLE_WRITE_AFTER_READ)
			idle_need = ab; // R12
		else if (last == EBIR_LAST_WRITE && !nwr && IDLE_ENABLE_READ_AFTER_WRITE)
			idle_need = idle_cycles(IDLE_COUNT_A, 1'b0); // R13
	endfunction

	assign rel_ok = EXT_EXTENDED_MODE && RELEASE_ENABLE && INPUT_BUFFER_CTRL
		&& !EXT_BUS_REQUEST_N; // R01

	ebir_clk_hold u_clk_hold (
		.CLK_SYS (CLK_SYS),
		.RST     (RST),
		.wr_stb  (CLK_SET_WR),
		.wr_data (CLK_SET_DATA),
		.hold    (st_q == EBIR_REL), // R06
		.setting (clk_setting),
		.pending (clk_pending)
	);

	always_comb begin
		st_d     = st_q;
		last_d   = last_q;
		area_d   = area_q;
		gap_d    = (gap_q == '1) ? gap_q : gap_q + CNT_ONE; // R16
		need_d   = need_q;
		addr_d   = addr_q;
		data_d   = data_q;
		cs_d     = CS_IDLE;
		wr_d     = 1'b0;
		rd_n_d   = 1'b1;
		wrs_n_d  = 1'b1;
		strb_n_d = 1'b1;
		hz_d     = 1'b0;
		ack_d    = 1'b1;
		float_d  = 1'b0;
		done_d   = 1'b0;
		stall_d  = 1'b0;
		cancel_d = 1'b1;
		case (st_q)
			EBIR_IDLE: begin
				if (rel_ok) begin
					st_d = EBIR_REL; // R08
					ack_d = 1'b0; // R03
					float_d = 1'b1;
					stall_d = ACC_REQ;
				end else if (ACC_REQ) begin
					need_d = idle_need(last_q, IDLE_SETTING_SELECT[area_q], ACC_WRITE,
						ACC_AREA == area_q);
					addr_d = ACC_ADDR; // R10
					data_d = ACC_WDATA;
					area_d = ACC_AREA;
					wr_d   = ACC_WRITE;
					stall_d = 1'b1;
					st_d   = EBIR_WAIT;
				end
			end
			EBIR_WAIT: begin
				wr_d = wr_q;
				stall_d = 1'b1;
				if (gap_q >= need_q) begin
					st_d = EBIR_ACC;
					cs_d[area_q] = 1'b0;
					strb_n_d = 1'b0;
					rd_n_d = wr_q;
					wrs_n_d = !wr_q;
				end
			end
			EBIR_ACC: begin
				st_d   = EBIR_IDLE;
				last_d = wr_q ? EBIR_LAST_WRITE : EBIR_LAST_READ;
				// The cycle after the strobe is already the first idle cycle
				gap_d  = CNT_ONE; // R16
				done_d = 1'b1;
			end
			EBIR_REL: begin
				float_d = 1'b1; // R09
				ack_d   = 1'b0;
				stall_d = ACC_REQ; // R05
				if (CANCEL_REQUEST_OUT_ENABLE && (ACC_REQ || SLEEP_STANDBY_REQ || CLK_SET_WR
					|| clk_pending))
					cancel_d = 1'b0; // R07
				if (EXT_BUS_REQUEST_N) begin
					st_d = EBIR_IDLE; // R15
					ack_d = 1'b1;
					float_d = 1'b0;
					cancel_d = 1'b1;
				end
			end
			default: st_d = EBIR_IDLE;
		endcase
		hz_d = float_d || wrs_n_d; // R10
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			st_q <= EBIR_IDLE;
			last_q <= EBIR_LAST_NONE;
			area_q <= '0;
			gap_q <= '1;
			need_q <= CNT_ZERO;
			addr_q <= '0;
			data_q <= '0;
			cs_q <= CS_IDLE;
			wr_q <= 1'b0;
			rd_n_q <= 1'b1;
			wrs_n_q <= 1'b1;
			strb_n_q <= 1'b1;
			hz_q <= 1'b1;
			ack_q <= 1'b1;
			float_q <= 1'b0;
			done_q <= 1'b0;
			stall_q <= 1'b0;
			cancel_q <= 1'b1;
		end else begin
			st_q <= st_d;
			last_q <= last_d;
			area_q <= area_d;
			gap_q <= gap_d;
			need_q <= need_d;
			addr_q <= addr_d;
			data_q <= data_d;
			cs_q <= cs_d;
			wr_q <= wr_d;
			rd_n_q <= rd_n_d;
			wrs_n_q <= wrs_n_d;
			strb_n_q <= strb_n_d;
			hz_q <= hz_d;
			ack_q <= ack_d;
			float_q <= float_d;
			done_q <= done_d;
			stall_q <= stall_d;
			cancel_q <= cancel_d;
		end
	end

	// Internal-space traffic never enters this block, so it runs on during release
	assign ACC_DONE = done_q; // R04
	assign ACC_STALL = stall_q;
	assign CLK_SETTING = clk_setting;
	assign BUS_ACK_N = ack_q;
	assign RELEASE_CANCEL_REQUEST_N = cancel_q;
	assign ADDR_O = addr_q;
	assign ADDR_OE_N = float_q;
	assign DATA_O = data_q;
	assign DATA_OE_N = hz_q;
	assign CHIP_SELECT_N = cs_q;
	assign ADDR_STROBE_N = strb_n_q;
	assign READ_N = rd_n_q;
	assign BUS_START_N = strb_n_q;
	assign READ_WRITE_N = wrs_n_q;
	assign ADDR_HOLD_N = 1'b0;
	assign UPPER_WRITE_STROBE_N = wrs_n_q;
	assign LOWER_WRITE_STROBE_N = wrs_n_q;
	assign UPPER_BYTE_SELECT_N = strb_n_q;
	assign LOWER_BYTE_SELECT_N = strb_n_q;
	assign CTRL_OE_N = float_q;

	a_release_acks: assert property (@(posedge CLK_SYS) disable iff (RST)
		(st_q == EBIR_IDLE && rel_ok) |=> (!BUS_ACK_N && ADDR_OE_N && CTRL_OE_N)) // R03
		else $error("release not acknowledged");
	a_release_floats: assert property (@(posedge CLK_SYS) disable iff (RST)
		!BUS_ACK_N |-> (ADDR_OE_N && DATA_OE_N && CTRL_OE_N)) // R09
		else $error("bus driven while released");
	a_release_defers: assert property (@(posedge CLK_SYS) disable iff (RST)
		!BUS_ACK_N |-> &CHIP_SELECT_N) // R05
		else $error("external cycle during release");
	a_release_gated: assert property (@(posedge CLK_SYS) disable iff (RST)
		(st_q == EBIR_IDLE && !(EXT_EXTENDED_MODE && RELEASE_ENABLE && INPUT_BUFFER_CTRL))
		|=> BUS_ACK_N) // R01
		else $error("release without enables");
	a_cancel_out: assert property (@(posedge CLK_SYS) disable iff (RST)
		!RELEASE_CANCEL_REQUEST_N |-> (!BUS_ACK_N && CANCEL_REQUEST_OUT_ENABLE)) // R07
		else $error("cancel request outside release");
	a_return_ack: assert property (@(posedge CLK_SYS) disable iff (RST)
		(st_q == EBIR_REL && EXT_BUS_REQUEST_N) |=> (BUS_ACK_N && !ADDR_OE_N)) // R15
		else $error("acknowledge not returned");
	a_idle_pins: assert property (@(posedge CLK_SYS) disable iff (RST)
		(st_q == EBIR_WAIT) |-> (&CHIP_SELECT_N && READ_N && DATA_OE_N && !ADDR_HOLD_N)) // R10
		else $error("idle pin state wrong");
	a_idle_count: assert property (@(posedge CLK_SYS) disable iff (RST)
		(st_q == EBIR_WAIT && gap_q < need_q) |=> &CHIP_SELECT_N) // R11
		else $error("access started before idle done");
	a_clk_defer: assert property (@(posedge CLK_SYS) disable iff (RST)
		(st_q == EBIR_REL && CLK_SET_WR) |=> $stable(CLK_SETTING)) // R06
		else $error("clock setting applied during release");
	c_release: cover property (@(posedge CLK_SYS) st_q == EBIR_IDLE ##1 st_q == EBIR_REL);
	c_idle_wait: cover property (@(posedge CLK_SYS) st_q == EBIR_WAIT ##1 st_q == EBIR_WAIT);
	c_cancel: cover property (@(posedge CLK_SYS) !RELEASE_CANCEL_REQUEST_N);
endmodule

// File: hdl/ebir_pkg.sv
// Package with constants and types for the external bus idle and release block
package ebir_pkg;
	localparam int ADDR_W      = 24;
	localparam int DATA_W      = 16;
	localparam int AREA_N      = 8;
	localparam int AREA_W      = 3;
	localparam int CNT_W       = 3;
	localparam int IDLE_RST_A  = 2;
	localparam int CLK_W       = 3;
	localparam logic [1:0] CODE_RST = 2'h3;
	localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
	localparam logic [CNT_W-1:0] CNT_ONE  = 3'h1;
	localparam logic [AREA_N-1:0] CS_IDLE = 8'hff;

	typedef enum logic [3:0] {
		EBIR_IDLE = 4'h1,
		EBIR_WAIT = 4'h2,
		EBIR_ACC  = 4'h4,
		EBIR_REL  = 4'h8
	} ebir_state_t;

	typedef enum logic [1:0] {
		EBIR_LAST_NONE  = 2'h0,
		EBIR_LAST_READ  = 2'h1,
		EBIR_LAST_WRITE = 2'h2
	} ebir_last_t;
endpackage

// File: hdl/ebir_clk_hold.sv
// Holding register for a deferred clock-frequency setting
`timescale 1ns/10ps
module ebir_clk_hold
	import ebir_pkg::*;
(
	input  wire logic             CLK_SYS,
	input  wire logic             RST,
	input  wire logic             wr_stb,
	input  wire logic [CLK_W-1:0] wr_data,
	input  wire logic             hold,
	output logic      [CLK_W-1:0] setting,
	output logic                  pending
);
	logic [CLK_W-1:0] buf_q, buf_d, set_q, set_d;
	logic             pend_q, pend_d;

	always_comb begin
		buf_d  = buf_q;
		set_d  = set_q;
		pend_d = pend_q;
		if (wr_stb && hold) begin
			buf_d  = wr_data;
			pend_d = 1'b1;
		end else if (wr_stb) begin
			set_d  = wr_data;
			pend_d = 1'b0;
		end else if (pend_q && !hold) begin
			set_d  = buf_q;
			pend_d = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			buf_q  <= '0;
			set_q  <= '0;
			pend_q <= 1'b0;
		end else begin
			buf_q  <= buf_d;
			set_q  <= set_d;
			pend_q <= pend_d;
		end
	end

	assign setting = set_q;
	assign pending = pend_q;
endmodule

// File: bench/ebir_ext_master.sv
// Model of the external bus master that borrows the shared bus
`timescale 1ns/10ps
module ebir_ext_master (
	input  wire logic CLK_SYS,
	input  wire logic want,
	output logic      EXT_BUS_REQUEST_N
);
	initial EXT_BUS_REQUEST_N = 1'b1;
	// Request is held low for the whole time the bus is wanted, never pulsed
	always @(posedge CLK_SYS) begin
		EXT_BUS_REQUEST_N <= #1 ~want;
	end
endmodule

// File: bench/testbench.sv
// Self-checking testbench for the idle-cycle and bus release controller
`timescale 1ns/10ps
module testbench
	import ebir_pkg::*;
;
	logic CLK_SYS = 0, RST = 1, EXT_EXTENDED_MODE = 1, RELEASE_ENABLE = 1, INPUT_BUFFER_CTRL = 1;
	logic CANCEL_REQUEST_OUT_ENABLE = 0, IDLE_ENABLE_READ_AFTER_WRITE = 1;
	logic IDLE_ENABLE_READ_READ = 1, IDLE_ENABLE_WRITE_AFTER_READ = 1;
	logic ACC_REQ = 0, ACC_WRITE = 0, SLEEP_STANDBY_REQ = 0, CLK_SET_WR = 0, want = 0;
	logic [AREA_N-1:0] IDLE_SETTING_SELECT = 8'h00;
	logic [1:0]        IDLE_COUNT_A = CODE_RST, IDLE_COUNT_B = CODE_RST;
	logic [AREA_W-1:0] ACC_AREA = 3'h0;
	logic [ADDR_W-1:0] ACC_ADDR = 24'h0, ADDR_O;
	logic [DATA_W-1:0] ACC_WDATA = 16'h5a5a, DATA_O;
	logic [CLK_W-1:0]  CLK_SET_DATA = 3'h0, CLK_SETTING;
	logic [AREA_N-1:0] CHIP_SELECT_N;
	logic [8:0]        p;
	logic EXT_BUS_REQUEST_N, ACC_DONE, ACC_STALL, BUS_ACK_N, RELEASE_CANCEL_REQUEST_N;
	logic ADDR_OE_N, DATA_OE_N, READ_N, ADDR_STROBE_N, BUS_START_N, READ_WRITE_N;
	logic ADDR_HOLD_N, CTRL_OE_N, UPPER_WRITE_STROBE_N, LOWER_WRITE_STROBE_N;
	logic UPPER_BYTE_SELECT_N, LOWER_BYTE_SELECT_N;
	int miscompares = 0, cmp_count = 0, cyc = 0, t_cs, t_rel, g;
	// Back-to-back requests still leave the done cycle and the take cycle idle
	localparam int IDLE_FLOOR = 2;

	ebir_top u_dut (.CLK_SYS, .RST, .EXT_EXTENDED_MODE, .RELEASE_ENABLE, .INPUT_BUFFER_CTRL,
		.CANCEL_REQUEST_OUT_ENABLE, .IDLE_ENABLE_READ_AFTER_WRITE, .IDLE_ENABLE_READ_READ,
		.IDLE_ENABLE_WRITE_AFTER_READ, .IDLE_SETTING_SELECT, .IDLE_COUNT_A, .IDLE_COUNT_B,
		.EXT_BUS_REQUEST_N, .ACC_REQ, .ACC_WRITE, .ACC_AREA, .ACC_ADDR, .ACC_WDATA,
		.SLEEP_STANDBY_REQ, .CLK_SET_WR, .CLK_SET_DATA, .ACC_DONE, .ACC_STALL, .CLK_SETTING,
		.BUS_ACK_N, .RELEASE_CANCEL_REQUEST_N, .ADDR_O, .ADDR_OE_N, .DATA_O, .DATA_OE_N,
		.CHIP_SELECT_N, .ADDR_STROBE_N, .READ_N, .BUS_START_N, .READ_WRITE_N, .ADDR_HOLD_N,
		.UPPER_WRITE_STROBE_N, .LOWER_WRITE_STROBE_N, .UPPER_BYTE_SELECT_N,
		.LOWER_BYTE_SELECT_N, .CTRL_OE_N);
	ebir_ext_master u_master (.CLK_SYS, .want, .EXT_BUS_REQUEST_N);

	initial forever #5 CLK_SYS = ~CLK_SYS;
	always @(posedge CLK_SYS) cyc <= cyc + 1;

	task complete_run;
		$display("Comparisons %0d miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %0h seen %0h", n, e, s);
		end
	endtask

	task automatic chk_idle(string n, int cycles);
		chk(n, (cycles > IDLE_FLOOR) ? cycles : IDLE_FLOOR, g);
	endtask

	task automatic step(int n = 1);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask

	// One external access; ip checks the pins of the cycle just before the strobe,
	// keep leaves the request up so that the next call follows back to back
	task automatic acc(logic w, logic [2:0] a, logic ip, logic keep);
		int k;
		logic [18:0] e, s;
		ACC_WRITE = w;
		ACC_AREA = a;
		ACC_ADDR = {a, 21'h0b3c5};
		ACC_REQ = 1;
		for (k = 0; k < 300 && CHIP_SELECT_N === CS_IDLE; k++) begin
			p = {ADDR_O == ACC_ADDR, DATA_OE_N, READ_N, ADDR_STROBE_N, BUS_START_N,
				READ_WRITE_N, UPPER_WRITE_STROBE_N, LOWER_WRITE_STROBE_N, ADDR_HOLD_N};
			step();
		end
		t_cs = cyc;
		if (ip) chk("idle pins", 9'h1fe, p);
		e = {2'h2, ~(8'h01 << a), w, {3{!w}}, 4'h0, !w};
		s = {BUS_ACK_N, CTRL_OE_N, CHIP_SELECT_N, READ_N, UPPER_WRITE_STROBE_N,
			LOWER_WRITE_STROBE_N, READ_WRITE_N, UPPER_BYTE_SELECT_N, LOWER_BYTE_SELECT_N,
			ADDR_STROBE_N, BUS_START_N, DATA_OE_N};
		chk("driven at strobe", e, s);
		if (w) chk("write data", ACC_WDATA, DATA_O);
		for (k = k; k < 320 && ACC_DONE !== 1'b1; k++) step();
		if (k >= 300) begin
			miscompares++;
			complete_run();
		end else if (!keep) begin
			ACC_REQ = 0;
			step();
		end
	endtask

	task automatic pair(logic w1, logic [2:0] a1, logic w2, logic [2:0] a2, logic ip);
		int t;
		acc(w1, a1, 0, 1);
		t = t_cs;
		acc(w2, a2, ip, 0);
		// Strobe-free cycles between the two strobes
		g = t_cs - t - 1;
	endtask

	initial begin
		step(2);
		RST = 0;
		chk("reset", {2'h3, CS_IDLE, 1'b1, 3'h0}, {BUS_ACK_N, RELEASE_CANCEL_REQUEST_N,
			CHIP_SELECT_N, DATA_OE_N, CLK_SETTING});
		pair(0, 0, 0, 1, 1);
		chk_idle("count a reset", 4);
		for (int i = 0; i < 3; i++) begin
			IDLE_COUNT_A = 2'(i);
			pair(0, 0, 0, 1, 0);
			chk_idle("count a code", i + 1);
		end
		IDLE_COUNT_A = CODE_RST;
		IDLE_ENABLE_READ_READ = 0;
		pair(0, 0, 0, 1, 0);
		chk_idle("read read off", 0);
		IDLE_ENABLE_READ_READ = 1;
		pair(0, 2, 0, 2, 0);
		chk_idle("same area", 0);
		IDLE_SETTING_SELECT = 8'h01;
		IDLE_COUNT_B = 2'h0;
		pair(0, 0, 0, 1, 0);
		chk_idle("count b zero", 0);
		IDLE_COUNT_B = 2'h2;
		pair(0, 0, 0, 1, 0);
		chk_idle("count b three", 3);
		pair(0, 0, 1, 0, 0);
		chk_idle("write after read", 3);
		IDLE_ENABLE_WRITE_AFTER_READ = 0;
		pair(0, 0, 1, 0, 0);
		chk_idle("war off", 0);
		IDLE_SETTING_SELECT = 8'hff;
		IDLE_COUNT_B = 2'h0;
		pair(1, 0, 0, 0, 1);
		chk_idle("read after write", 4);
		// Each enable in turn held low must refuse the request
		for (int i = 0; i < 3; i++) begin
			{EXT_EXTENDED_MODE, RELEASE_ENABLE, INPUT_BUFFER_CTRL} = 3'h7 ^ (3'h1 << i);
			want = 1;
			step(20);
			chk("ack refused", 1, BUS_ACK_N);
			want = 0;
			step(3);
		end
		{EXT_EXTENDED_MODE, RELEASE_ENABLE, INPUT_BUFFER_CTRL} = 3'h7;
		CANCEL_REQUEST_OUT_ENABLE = 1;
		IDLE_ENABLE_READ_READ = 0;
		IDLE_ENABLE_READ_AFTER_WRITE = 0;
		t_rel = 1 << 30;
		fork
			begin
				step();
				acc(0, 3, 0, 0);
			end
			begin
				want = 1;
				step(6);
				chk("ack", 0, BUS_ACK_N);
				chk("float", 3'h7, {ADDR_OE_N, DATA_OE_N, CTRL_OE_N});
				chk("stall", 1, ACC_STALL);
				chk("cancel", 0, RELEASE_CANCEL_REQUEST_N);
				CLK_SET_DATA = 3'h5;
				CLK_SET_WR = 1;
				step();
				CLK_SET_WR = 0;
				step(3);
				chk("clk held", 0, CLK_SETTING);
				t_rel = cyc;
				want = 0;
			end
		join
		chk("deferred", 1, t_cs > t_rel);
		chk("clk applied", 5, CLK_SETTING);
		CANCEL_REQUEST_OUT_ENABLE = 0;
		want = 1;
		step(6);
		SLEEP_STANDBY_REQ = 1;
		step(3);
		chk("cancel off", 1, RELEASE_CANCEL_REQUEST_N);
		CANCEL_REQUEST_OUT_ENABLE = 1;
		step(3);
		chk("cancel sleep", 0, RELEASE_CANCEL_REQUEST_N);
		SLEEP_STANDBY_REQ = 0;
		want = 0;
		step(6);
		chk("ack back", 1, BUS_ACK_N);
		complete_run();
	end
endmodule
